// ===== src/atesc_parser.v
`timescale 1ns/1ns
`include "atesc_consts.vh"
module atesc_parser #(
  parameter LINE_MAX = `ATESC_LINE_MAX,
  parameter GUARD_STEP_CYC = `ATESC_GUARD_STEP_CYC
) (
  input wire clk,
  input wire nrst,
  input wire async_port,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire guard_wr,
  input wire [7:0] guard_wdata,
  input wire term_wr,
  input wire [7:0] term_wdata,
  input wire profile_wr,
  input wire profile_wsel,
  input wire cmd_return,
  output reg cmd_mode,
  output reg data_valid,
  output reg [7:0] data_char,
  output reg line_exec,
  output reg line_error,
  output reg [5:0] line_len,
  output reg [8*LINE_MAX-1:0] line_buf,
  output reg profile_apply,
  output reg profile_sel,
  output reg [7:0] guard_time_setting,
  output reg [7:0] terminator_char_setting
);
  localparam ST_DATA = 4'b0001;
  localparam ST_ESC = 4'b0010;
  localparam ST_WAITA = 4'b0100;
  localparam ST_LINE = 4'b1000;
  reg [3:0] state;
  reg [1:0] plus_cnt;
  reg seen_t;
  reg overflow;
  reg [2:0] pend_cnt;
  reg [31:0] pend_buf;
  reg [2:0] next_pend_cnt;
  reg [31:0] next_pend_buf;
  reg async_q;
  reg nv_profile = `ATESC_PROFILE_DEF;
  reg boot;
  wire rx_ok;
  wire guard_exp;
  wire [7:0] up_char;
  wire [39:0] guard_limit;
  wire [7:0] eff_guard;
  wire esc_more;
  wire esc_fail;
  wire pend_load;
  wire pend_push;
  // zero guard would make every plus a gap; treat it as one step
  assign eff_guard = (guard_time_setting == 8'h00) ? 8'h01 : guard_time_setting;
  assign guard_limit = eff_guard * GUARD_STEP_CYC[31:0];
  // clearing bit 5 folds a to A and t to T; no other code lands on either
  assign up_char = rx_char & `ATESC_CASE_BIT;
  assign rx_ok = rx_valid;
  assign esc_more = (rx_char == `ATESC_CHAR_PLUS) && !guard_exp && (plus_cnt != 2'd3);
  assign esc_fail = rx_ok ? !esc_more : (guard_exp && (plus_cnt != 2'd3));
  assign pend_load = (state == ST_ESC) && esc_fail;
  // data arriving while pluses still drain waits behind them, so order is kept
  assign pend_push = (state == ST_DATA) && rx_ok && (pend_cnt != 3'd0);
  ////////////////////////////////////////////////////////////////////////////
  // port select is a pin level from another domain
  wire async_sync;
  atesc_sync3 u_async_sync (
    .clk(clk),
    .nrst(nrst),
    .din(async_port),
    .dout(async_sync)
  );
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      async_q <= 1'b0;
    end else begin
      async_q <= async_sync;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // line silence timer restarts on each received character
  // a command-mode character restarts it too, which is harmless there
  atesc_gtimer #(
    .W(40)
  ) u_guard (
    .clk(clk),
    .nrst(nrst),
    .restart(rx_ok),
    .limit(guard_limit),
    .expired(guard_exp)
  );
  ////////////////////////////////////////////////////////////////////////////
  // settings registers
  // a zero guard written here still acts as one step, see eff_guard
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      guard_time_setting <= `ATESC_GUARD_SET_DEF;
      terminator_char_setting <= `ATESC_CHAR_CR;
    end else begin
      if (guard_wr) begin
        guard_time_setting <= guard_wdata;
      end
      if (term_wr) begin
        terminator_char_setting <= term_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile copy: kept out of reset so every reset reapplies the last stored profile
  always @(posedge clk) begin
    if (profile_wr) begin
      nv_profile <= profile_wsel;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // stored profile applied just after reset, then follows each new write
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot <= 1'b1;
      profile_apply <= 1'b0;
      profile_sel <= `ATESC_PROFILE_DEF;
    end else begin
      boot <= 1'b0;
      profile_apply <= boot;
      if (profile_wr) begin
        profile_sel <= profile_wsel;
      end else if (boot) begin
        profile_sel <= nv_profile;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pass-through queue: up to three held pluses, one out per cycle; an arrival never
  // outpaces the drain, so four places are always enough
  always @* begin
    next_pend_buf = pend_buf;
    next_pend_cnt = pend_cnt;
    if (pend_cnt != 3'd0) begin
      next_pend_buf = {8'h00, pend_buf[31:8]};
      next_pend_cnt = pend_cnt - 3'd1;
    end
    if (pend_load) begin
      next_pend_buf = {4{`ATESC_CHAR_PLUS}};
      next_pend_cnt = {1'b0, plus_cnt};
    end else if (pend_push) begin
      next_pend_buf[next_pend_cnt*8 +: 8] = rx_char;
      next_pend_cnt = next_pend_cnt + 3'd1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main mode machine
  // one-hot states; data_valid, line_exec and line_error are one-cycle pulses, other outputs hold their values
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_DATA;
      plus_cnt <= 2'd0;
      seen_t <= 1'b0;
      overflow <= 1'b0;
      pend_cnt <= 3'd0;
      pend_buf <= 32'h0000_0000;
      cmd_mode <= 1'b0;
      data_valid <= 1'b0;
      data_char <= 8'h00;
      line_exec <= 1'b0;
      line_error <= 1'b0;
      line_len <= 6'd0;
      line_buf <= {(8*LINE_MAX){1'b0}};
    end else begin
      data_valid <= 1'b0;
      line_exec <= 1'b0;
      line_error <= 1'b0;
      // queued characters leave one per cycle, oldest first
      if (pend_cnt != 3'd0) begin
        data_valid <= 1'b1;
        data_char <= pend_buf[7:0];
      end
      pend_cnt <= next_pend_cnt;
      pend_buf <= next_pend_buf;
      case (state)
        ST_DATA: begin
          cmd_mode <= 1'b0;
          if (rx_ok) begin
            // plus counts only after guard silence
            if (rx_char == `ATESC_CHAR_PLUS && guard_exp && pend_cnt == 3'd0) begin
              state <= ST_ESC;
              plus_cnt <= 2'd1;
            end else if (pend_cnt == 3'd0) begin
              data_valid <= 1'b1;
              data_char <= rx_char;
            end
          end
        end
        ST_ESC: begin
          if (rx_ok) begin
            // gap of guard or more voids escape
            if (esc_more) begin
              plus_cnt <= plus_cnt + 2'd1;
            end else begin
              // failed escape passes pluses as data
              state <= ST_DATA;
              plus_cnt <= 2'd0;
            end
          end else if (guard_exp) begin
            if (plus_cnt == 2'd3) begin
              state <= ST_WAITA;
              cmd_mode <= 1'b1;
            end else begin
              state <= ST_DATA;
            end
            plus_cnt <= 2'd0;
          end
        end
        ST_WAITA: begin
          // a fresh line always starts without its T
          seen_t <= 1'b0;
          if (cmd_return) begin
            state <= ST_DATA;
            cmd_mode <= 1'b0;
          // only async port in command mode
          end else if (rx_ok && async_q) begin
            if (up_char == `ATESC_CHAR_A_UP) begin
              state <= ST_LINE;
              line_len <= 6'd0;
              overflow <= 1'b0;
            end
          end
        end
        ST_LINE: begin
          // the executor may end command mode in mid-line; the partial line is lost
          if (cmd_return) begin
            state <= ST_DATA;
            cmd_mode <= 1'b0;
          end else if (rx_ok && async_q) begin
            if (rx_char == terminator_char_setting) begin
              line_exec <= seen_t && !overflow;
              line_error <= !seen_t || overflow;
              state <= ST_WAITA;
            end else if (rx_char == `ATESC_CHAR_BS) begin
              if (line_len != 6'd0) begin
                line_len <= line_len - 6'd1;
              end else if (seen_t) begin
                // empty line: backspace takes back the T, then the A
                seen_t <= 1'b0;
              end else begin
                state <= ST_WAITA;
              end
            end else if (!seen_t) begin
              if (up_char == `ATESC_CHAR_T_UP) begin
                seen_t <= 1'b1;
              end else begin
                state <= ST_WAITA;
              end
            end else if (rx_char == `ATESC_CHAR_SPACE) begin
              line_len <= line_len;
            end else if (line_len < LINE_MAX[5:0]) begin
              line_buf[line_len*8 +: 8] <= rx_char;
              line_len <= line_len + 6'd1;
            end else begin
              // the line keeps its first forty characters only
              // drop excess characters
              overflow <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_DATA;
        end
      endcase
    end
  end
endmodule

// ===== pkg/atesc_consts.vh
`ifndef ATESC_CONSTS_VH
`define ATESC_CONSTS_VH
// character codes
`define ATESC_CHAR_PLUS 8'h2b
`define ATESC_CHAR_SPACE 8'h20
`define ATESC_CHAR_BS 8'h08
`define ATESC_CHAR_CR 8'h0d
`define ATESC_CHAR_A_UP 8'h41
`define ATESC_CHAR_T_UP 8'h54
`define ATESC_CASE_BIT 8'hdf
// line length limit
`define ATESC_LINE_MAX 40
// clock and guard time
`define ATESC_CLK_MHZ 250
`define ATESC_GUARD_MS 1000
`define ATESC_GUARD_DEF (`ATESC_GUARD_MS * 1000 * `ATESC_CLK_MHZ)
// guard setting unit: one step = 20 ms
`define ATESC_GUARD_STEP_MS 20
`define ATESC_GUARD_STEP_CYC (`ATESC_GUARD_STEP_MS * 1000 * `ATESC_CLK_MHZ)
`define ATESC_GUARD_SET_DEF 8'h32
// profile selection
`define ATESC_PROFILE_DEF 1'b0
`endif

// ===== src/atesc_sync3.v
`timescale 1ns/1ns
`include "atesc_consts.vh"
// three-stage input synchroniser; output changes once stages two and three agree
module atesc_sync3 (
  input wire clk,
  input wire nrst,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  ////////////////////////////////////////////////////////////////////////////
  // s1 is only read by s2, to keep metastability out of the logic
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// ===== src/atesc_gtimer.v
`timescale 1ns/1ns
`include "atesc_consts.vh"
// silence timer: counts since the last restart, flags once limit is reached
module atesc_gtimer #(
  parameter W = 32
) (
  input wire clk,
  input wire nrst,
  input wire restart,
  input wire [W-1:0] limit,
  output reg expired
);
  reg [W-1:0] count;
  ////////////////////////////////////////////////////////////////////////////
  // saturating count so a long idle line stays expired
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= {W{1'b0}};
      expired <= 1'b0;
    end else if (restart) begin
      count <= {W{1'b0}};
      expired <= 1'b0;
    end else begin
      if (count < limit) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
      expired <= (count + {{(W-1){1'b0}}, 1'b1} >= limit);
    end
  end
endmodule

// ===== testbench/atesc_dte.sv
`timescale 1ns/1ns
// async terminal model: one character per put, inverse data between characters
module atesc_dte (
  input wire clk,
  output reg rx_valid,
  output reg [7:0] rx_char
);
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  task put(input [7:0] c);
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_char = c;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_char = ~c;
    end
  endtask
endmodule

// ===== testbench/atesc_chk.sv
`timescale 1ns/1ns
// port checker; one clock domain, so default clocking and disable
module atesc_chk #(
  parameter LINE_MAX = 40,
  parameter GUARD_STEP_CYC = 20
) (
  input wire clk,
  input wire nrst,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire guard_wr,
  input wire [7:0] guard_wdata,
  input wire term_wr,
  input wire cmd_mode,
  input wire data_valid,
  input wire line_exec,
  input wire line_error,
  input wire [5:0] line_len,
  input wire [7:0] guard_time_setting,
  input wire [7:0] terminator_char_setting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reg [31:0] idle;
  // silence counter; saturates so long quiet spells never wrap
  always @(posedge clk or negedge nrst) begin
    if (!nrst) idle <= 32'h0000_0000;
    else if (rx_valid) idle <= 32'h0000_0000;
    else if (idle != 32'hffff_ffff) idle <= idle + 32'h0000_0001;
  end
  property p_gw; guard_wr |=> guard_time_setting == $past(guard_wdata); endproperty
  a_gw: assert property (p_gw) else $error("guard write lost");
  property p_th; !term_wr |=> $stable(terminator_char_setting); endproperty
  a_th: assert property (p_th) else $error("terminator moved");
  property p_cause; line_exec || line_error |-> $past(rx_valid) &&
    $past(rx_char) == $past(terminator_char_setting); endproperty
  a_cause: assert property (p_cause) else $error("line end without terminator");
  property p_len; line_len <= LINE_MAX; endproperty
  a_len: assert property (p_len) else $error("line too long");
  property p_excl; !(line_exec && line_error); endproperty
  a_excl: assert property (p_excl) else $error("exec and error together");
  property p_exec; line_exec |-> cmd_mode; endproperty
  a_exec: assert property (p_exec) else $error("exec outside command mode");
  property p_data; data_valid |-> !cmd_mode; endproperty
  a_data: assert property (p_data) else $error("data in command mode");
  property p_rise;
    $rose(cmd_mode) |-> idle >= guard_time_setting * GUARD_STEP_CYC;
  endproperty
  a_rise: assert property (p_rise) else $error("escape without trailing silence");
  c_cmd: cover property ($rose(cmd_mode));
  c_exec: cover property (line_exec);
  c_err: cover property (line_error);
endmodule
bind atesc_parser atesc_chk #(.LINE_MAX(LINE_MAX), .GUARD_STEP_CYC(GUARD_STEP_CYC))
  atesc_chk_i (.*);

// ===== testbench/tb_at_command_escape_parser.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_at_command_escape_parser;
  localparam G = 40; // guard of 2 steps of 20 cycles
  reg clk = 1'b0, nrst = 1'b0, async_port = 1'b1, guard_wr = 1'b0, term_wr = 1'b0;
  reg profile_wr = 1'b0, profile_wsel = 1'b0, cmd_return = 1'b0;
  reg [7:0] guard_wdata = 8'h02, term_wdata = 8'h00, last_data;
  wire rx_valid, cmd_mode, data_valid, line_exec, line_error, profile_apply, profile_sel;
  wire [7:0] rx_char, data_char, gset, tset;
  wire [5:0] line_len;
  wire [319:0] line_buf;
  integer n_fail = 0, compares = 0, n_data = 0, n_exec = 0, n_err = 0, b0, b1;
  initial forever #2 clk = ~clk;
  atesc_dte atesc_dte_i (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char));
  atesc_parser #(.GUARD_STEP_CYC(20)) atesc_parser_i (.clk(clk), .nrst(nrst),
    .async_port(async_port), .rx_valid(rx_valid), .rx_char(rx_char), .guard_wr(guard_wr),
    .guard_wdata(guard_wdata), .term_wr(term_wr), .term_wdata(term_wdata),
    .profile_wr(profile_wr), .profile_wsel(profile_wsel), .cmd_return(cmd_return),
    .cmd_mode(cmd_mode), .data_valid(data_valid), .data_char(data_char),
    .line_exec(line_exec), .line_error(line_error), .line_len(line_len),
    .line_buf(line_buf), .profile_apply(profile_apply), .profile_sel(profile_sel),
    .guard_time_setting(gset), .terminator_char_setting(tset));
  // output pulse counters; old values are read at the edge, so no race
  always @(posedge clk) begin
    n_data += (data_valid === 1'b1);
    n_exec += (line_exec === 1'b1);
    n_err += (line_error === 1'b1);
    if (data_valid === 1'b1) last_data = data_char;
  end
  task tally_and_finish;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task cyc(input integer n); repeat (n) @(negedge clk); endtask
  task send(input string s);
    for (int k = 0; k < s.len(); k++) atesc_dte_i.put(s[k]);
  endtask
  task wait_cmd(input e);
    begin
      for (int k = 0; k < 100 && cmd_mode !== e; k++) cyc(1);
      `CHK("cmd_mode wait", e, cmd_mode)
      if (cmd_mode !== e) tally_and_finish;
    end
  endtask
  task do_reset(input e);
    begin
      nrst = 1'b0;
      cyc(10);
      nrst = 1'b1;
      @(posedge clk);
      #1 `CHK("profile_apply", 1'b1, profile_apply)
      `CHK("profile_sel", e, profile_sel)
      `CHK("guard", 8'h32, gset)
      `CHK("term", 8'h0d, tset)
      cyc(2);
      `CHK("apply pulse", 1'b0, profile_apply)
      $display("reset done");
    end
  endtask
  task set_term(input [7:0] v);
    begin
      term_wdata = v;
      term_wr = 1'b1;
      cyc(1);
      term_wr = 1'b0;
      cyc(1);
      `CHK("term write", v, tset)
    end
  endtask
  initial begin
    do_reset(1'b0);
    guard_wr = 1'b1;
    cyc(1);
    guard_wr = 1'b0;
    cyc(G + 10);
    `CHK("guard write", 8'h02, gset)
    b0 = n_data;
    send("x+++");
    cyc(G + 20);
    `CHK("no guard before", 4, n_data - b0)
    b0 = n_data;
    // gaps of guard plus five void it
    repeat (3) begin
      send("+");
      cyc(G + 5);
    end
    cyc(G);
    `CHK("gap voids", 4'd3, n_data - b0)
    `CHK("gap cmd", 1'b0, cmd_mode)
    b0 = n_data;
    send("+++");
    cyc(G / 2);
    `CHK("early cmd", 1'b0, cmd_mode)
    wait_cmd(1'b1);
    `CHK("held pluses", 0, n_data - b0)
    $display("escape done");
    b0 = n_exec;
    send("aT b\010C d\015");
    cyc(3);
    `CHK("exec", 1, n_exec - b0)
    `CHK("len", 6'd2, line_len)
    `CHK("buf", 16'h6443, line_buf[15:0])
    set_term(8'h21);
    b0 = n_exec;
    send("ATZ\015");
    cyc(3);
    `CHK("no term", 0, n_exec - b0)
    send("!");
    cyc(3);
    `CHK("new term", 1, n_exec - b0)
    set_term(8'h0d);
    $display("line done");
    b0 = n_exec;
    b1 = n_err;
    send("AT");
    repeat (45) send("X");
    send("\015");
    cyc(3);
    `CHK("ovf exec", 0, n_exec - b0)
    `CHK("ovf err", 1, n_err - b1)
    `CHK("ovf len", 6'd40, line_len)
    async_port = 1'b0;
    cyc(10);
    send("ATQ\015");
    cyc(3);
    `CHK("sync port", 0, n_exec - b0)
    async_port = 1'b1;
    cmd_return = 1'b1;
    cyc(1);
    cmd_return = 1'b0;
    wait_cmd(1'b0);
    b0 = n_data;
    send("y");
    cyc(3);
    `CHK("data back", 8'h79, last_data)
    cyc(G + 5);
    b0 = n_data;
    send("++yz");
    cyc(5);
    `CHK("order kept", 8'h7a, last_data)
    `CHK("broken escape", 3, n_data - b0)
    $display("mode done");
    profile_wsel = 1'b1;
    profile_wr = 1'b1;
    cyc(1);
    profile_wr = 1'b0;
    cyc(2);
    do_reset(1'b1);
    tally_and_finish;
  end
endmodule
